// ---- hw/sai_pkg.sv ----
// constants for the station address and status indicator block
package sai_pkg;
    // register byte offsets
    localparam logic [7:0] SAI_CTRL_OFS      = 8'h00;
    localparam logic [7:0] SAI_STATUS_OFS    = 8'h04;
    localparam logic [7:0] SAI_IRQ_STAT_OFS  = 8'h08;
    localparam logic [7:0] SAI_IRQ_MASK_OFS  = 8'h0C;
    localparam logic [7:0] SAI_CHAN_DIAG_OFS = 8'h10;
    localparam logic [7:0] SAI_FRAME_LEN_OFS = 8'h14;
    // control fields
    localparam int         SAI_CTRL_DPV1_BIT = 0;
    localparam logic       SAI_CTRL_RST      = 1'h0;
    // status fields
    localparam int         SAI_ST_VALID_BIT  = 8;
    localparam int         SAI_ST_BUSEN_BIT  = 9;
    localparam int         SAI_ST_PEND_BIT   = 10;
    localparam int         SAI_ST_LAMP_BIT   = 11;
    // interrupt status fields, mask has the same layout
    localparam int         SAI_IRQ_ALARM_BIT = 0;
    localparam int         SAI_IRQ_BADAD_BIT = 1;
    localparam int         SAI_IRQ_ACK_BIT   = 2;
    localparam int         SAI_IRQ_W         = 3;
    localparam logic [2:0] SAI_IRQ_MASK_RST  = 3'h0;
    // station address range
    localparam int         SAI_ADDR_W        = 7;
    localparam logic [6:0] SAI_ADDR_MIN      = 7'h01;
    localparam logic [6:0] SAI_ADDR_MAX      = 7'h7D;
    // diagnostics frame sizing in bytes
    localparam int         SAI_FRAME_HDR     = 6;
    localparam int         SAI_FRAME_MAX     = 244;
    localparam int         SAI_ENTRY_BYTES   = 3;
    localparam int         SAI_INT_BLK_BYTES = 4;
    localparam int         SAI_CHANNELS      = 8;
    // timing
    localparam int         SAI_CLK_HZ        = 40_000_000;
    localparam int         SAI_LAMP_MS       = 250;
    localparam int         SAI_FLASH_HALF_MS = 250;
    localparam int         SAI_LAMP_CYC      = SAI_LAMP_MS * (SAI_CLK_HZ / 1000);
    localparam int         SAI_FLASH_CYC     = SAI_FLASH_HALF_MS * (SAI_CLK_HZ / 1000);
    localparam int         SAI_SETTLE_CYC    = 3;
    localparam int         SAI_CNT_W         = 24;

    typedef enum logic [1:0] {SAI_CAPTURE, SAI_LAMP, SAI_RUN} sai_state_e;
endpackage

// ---- hw/sai_top.sv ----
// station address capture, status indicators and diagnostic interrupt logic
`timescale 1ns/1ps
module sai_top
    import sai_pkg::*;
#(
    parameter int NCH       = sai_pkg::SAI_CHANNELS,
    parameter int LAMP_CYC  = sai_pkg::SAI_LAMP_CYC,
    parameter int FLASH_CYC = sai_pkg::SAI_FLASH_CYC
)(
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    // address switch pins
    input  wire logic [sai_pkg::SAI_ADDR_W-1:0] addr_switch,
    // module state from the bus engine
    input  wire logic                       mod_deactivated,
    input  wire logic                       mod_not_configured,
    input  wire logic                       mod_starting,
    input  wire logic                       mod_configuring,
    input  wire logic                       data_exchange,
    input  wire logic                       group_error,
    input  wire logic                       config_mismatch,
    input  wire logic                       invalid_config,
    input  wire logic                       io_param_error,
    // diagnostic alarms and master acknowledge
    input  wire logic                       diag_alarm,
    input  wire logic [$clog2(NCH)-1:0]     diag_channel,
    input  wire logic                       diag_ack,
    // register port
    input  wire logic [7:0]                 reg_addr,
    input  wire logic [31:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [31:0]                reg_rdata,
    // indicators
    output logic                            run_led,
    output logic                            error_led,
    output logic                            maintenance_indicator,
    // bus side status
    output logic      [sai_pkg::SAI_ADDR_W-1:0] station_addr,
    output logic                            addr_valid,
    output logic                            bus_enable,
    output logic                            diag_int_pending,
    output logic      [7:0]                 frame_len,
    output logic                            irq
);
    import sai_pkg::*;

    sai_state_e                 state_r;
    logic [SAI_ADDR_W-1:0]      sw_s1_r;
    logic [SAI_ADDR_W-1:0]      sw_s2_r;
    logic [SAI_ADDR_W-1:0]      sw_s3_r;
    logic [1:0]                 settle_r;
    logic [SAI_CNT_W-1:0]       lamp_cnt_r;
    logic [SAI_CNT_W-1:0]       flash_cnt_r;
    logic                       flash_r;
    logic [SAI_ADDR_W-1:0]      addr_r;
    logic                       valid_r;
    logic                       dpv1_r;
    logic [SAI_IRQ_W-1:0]       irq_stat_r;
    logic [SAI_IRQ_W-1:0]       irq_mask_r;
    logic [SAI_IRQ_W-1:0]       irq_set;
    logic [NCH-1:0]             chan_r;
    logic                       pend_r;
    logic                       queued_r;
    logic                       run_nxt;
    logic                       err_nxt;
    logic                       maintenance_indicator_nxt;
    logic [7:0]                 len_nxt;
    logic                       capture;
    logic                       alarm_ok;
    logic                       ack_ok;
    logic                       any_err;
    logic                       in_run;

    // switch synchroniser; only the last two stages are compared
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sw_s1_r <= '0;
            sw_s2_r <= '0;
            sw_s3_r <= '0;
        end
        else
        begin
            sw_s1_r <= addr_switch;
            sw_s2_r <= sw_s1_r;
            sw_s3_r <= sw_s2_r;
        end
    end

    // chain must be filled before the one and only sample
    assign capture = (state_r == SAI_CAPTURE) && (settle_r == 2'(SAI_SETTLE_CYC))
                     && (sw_s2_r == sw_s3_r);
    assign in_run  = (state_r == SAI_RUN);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            settle_r <= '0;
        else if (state_r == SAI_CAPTURE && settle_r != 2'(SAI_SETTLE_CYC))
            settle_r <= settle_r + 2'h1;
    end

    // address held from power-up onward, never resampled
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            addr_r  <= '0;
            valid_r <= 1'b0;
        end
        else if (capture)
        begin
            addr_r  <= sw_s3_r;
            valid_r <= (sw_s3_r >= SAI_ADDR_MIN) && (sw_s3_r <= SAI_ADDR_MAX);
        end
    end

    // startup sequence
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r    <= SAI_CAPTURE;
            lamp_cnt_r <= '0;
        end
        else
        begin
            case (state_r)
                SAI_CAPTURE:
                    if (capture)
                        state_r <= SAI_LAMP;
                SAI_LAMP:
                    if (lamp_cnt_r == SAI_CNT_W'(LAMP_CYC - 1))
                        state_r <= SAI_RUN;
                    else
                        lamp_cnt_r <= lamp_cnt_r + SAI_CNT_W'(1);
                default:
                    state_r <= SAI_RUN;
            endcase
        end
    end

    // free running flash clock for all flashing indicators
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flash_cnt_r <= '0;
            flash_r     <= 1'b0;
        end
        else if (flash_cnt_r == SAI_CNT_W'(FLASH_CYC - 1))
        begin
            flash_cnt_r <= '0;
            flash_r     <= !flash_r;
        end
        else
            flash_cnt_r <= flash_cnt_r + SAI_CNT_W'(1);
    end

    // io_param_error is deliberately left out of the error term
    assign any_err = group_error || config_mismatch || invalid_config
                     || (|chan_r) || pend_r;

    always_comb
    begin
        run_nxt   = 1'b0;
        err_nxt   = 1'b0;
        maintenance_indicator_nxt = 1'b0;
        if (state_r == SAI_LAMP)
        begin
            run_nxt   = 1'b1;
            err_nxt   = 1'b1;
            maintenance_indicator_nxt = 1'b1;
        end
        else if (in_run && !valid_r)
        begin
            run_nxt = 1'b1;
            err_nxt = 1'b1;
        end
        else if (in_run)
        begin
            run_nxt = data_exchange ? 1'b1 : flash_r;
            err_nxt = any_err && flash_r;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            run_led               <= 1'b0;
            error_led             <= 1'b0;
            maintenance_indicator <= 1'b0;
        end
        else
        begin
            run_led               <= run_nxt;
            error_led             <= err_nxt;
            maintenance_indicator <= maintenance_indicator_nxt;
        end
    end

    // diagnostic interrupt handshake with the master
    assign alarm_ok = diag_alarm && dpv1_r && in_run && valid_r;
    assign ack_ok   = diag_ack && pend_r;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pend_r   <= 1'b0;
            queued_r <= 1'b0;
        end
        else if (ack_ok)
        begin
            // a queued or simultaneous alarm is raised straight after the ack
            pend_r   <= queued_r || alarm_ok;
            queued_r <= 1'b0;
        end
        else if (alarm_ok && pend_r)
            queued_r <= 1'b1;
        else if (alarm_ok)
            pend_r   <= 1'b1;
    end

    // channel diagnostics; software clears by writing ones, an alarm wins
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            chan_r <= '0;
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                if (alarm_ok && diag_channel == ($clog2(NCH))'(i))
                    chan_r[i] <= 1'b1;
                else if (reg_wr && reg_addr == SAI_CHAN_DIAG_OFS && reg_wdata[i])
                    chan_r[i] <= 1'b0;
            end
        end
    end

    // frame length from entries present, clamped to the frame limit
    always_comb
    begin
        int n;
        n = SAI_FRAME_HDR + (pend_r ? SAI_INT_BLK_BYTES : 0);
        for (int i = 0; i < NCH; i++)
            n = n + (chan_r[i] ? SAI_ENTRY_BYTES : 0);
        len_nxt = (n > SAI_FRAME_MAX) ? 8'(SAI_FRAME_MAX) : 8'(n);
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            frame_len <= 8'(SAI_FRAME_HDR);
        else
            frame_len <= len_nxt;
    end

    // control register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            dpv1_r <= SAI_CTRL_RST;
        else if (reg_wr && reg_addr == SAI_CTRL_OFS)
            dpv1_r <= reg_wdata[SAI_CTRL_DPV1_BIT];
    end

    // interrupt status and mask; a set in the clearing cycle wins
    always_comb
    begin
        irq_set                    = '0;
        irq_set[SAI_IRQ_ALARM_BIT] = alarm_ok;
        irq_set[SAI_IRQ_BADAD_BIT] = capture && !((sw_s3_r >= SAI_ADDR_MIN)
                                                  && (sw_s3_r <= SAI_ADDR_MAX));
        irq_set[SAI_IRQ_ACK_BIT]   = ack_ok;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            irq_stat_r <= '0;
        else if (reg_wr && reg_addr == SAI_IRQ_STAT_OFS)
            irq_stat_r <= (irq_stat_r & ~reg_wdata[SAI_IRQ_W-1:0]) | irq_set;
        else
            irq_stat_r <= irq_stat_r | irq_set;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            irq_mask_r <= SAI_IRQ_MASK_RST;
        else if (reg_wr && reg_addr == SAI_IRQ_MASK_OFS)
            irq_mask_r <= reg_wdata[SAI_IRQ_W-1:0];
    end

    // read port, data valid in the cycle after the strobe only
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= '0;
        else if (!reg_rd)
            reg_rdata <= '0;
        else if (reg_addr == SAI_CTRL_OFS)
            reg_rdata <= {31'h0, dpv1_r};
        else if (reg_addr == SAI_STATUS_OFS)
            reg_rdata <= {20'h0, (state_r == SAI_LAMP), pend_r, bus_enable, valid_r,
                          1'b0, addr_r};
        else if (reg_addr == SAI_IRQ_STAT_OFS)
            reg_rdata <= {29'h0, irq_stat_r};
        else if (reg_addr == SAI_IRQ_MASK_OFS)
            reg_rdata <= {29'h0, irq_mask_r};
        else if (reg_addr == SAI_CHAN_DIAG_OFS)
            reg_rdata <= 32'(chan_r);
        else if (reg_addr == SAI_FRAME_LEN_OFS)
            reg_rdata <= {24'h0, frame_len};
        else
            reg_rdata <= '0;
    end

    assign station_addr     = addr_r;
    assign addr_valid       = valid_r;
    assign bus_enable       = in_run && valid_r;
    assign diag_int_pending = pend_r;
    assign irq              = |(irq_stat_r & irq_mask_r);

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_alarm;
        alarm_ok && !pend_r;
    endsequence

    sequence s_pending_unacked;
        pend_r && !diag_ack;
    endsequence

    sequence s_ack_idle;
        ack_ok && !queued_r && !alarm_ok;
    endsequence

    addr_hold_a: assert property (in_run |=> $stable(addr_r))
        else $error("station address changed after capture");

    addr_range_a: assert property (in_run |-> valid_r ==
        (addr_r >= SAI_ADDR_MIN && addr_r <= SAI_ADDR_MAX))
        else $error("address validity does not match range");

    bad_addr_led_a: assert property (in_run && !valid_r |=>
        run_led && error_led && !maintenance_indicator)
        else $error("invalid address indicator pattern wrong");

    lamp_len_a: assert property ($fell(state_r == SAI_LAMP) |->
        $past(lamp_cnt_r) == SAI_CNT_W'(LAMP_CYC - 1))
        else $error("lamp test length wrong");

    lamp_led_a: assert property (state_r == SAI_LAMP |=>
        run_led && error_led && maintenance_indicator)
        else $error("lamp test does not light all indicators");

    startup_led_a: assert property (in_run && valid_r && !data_exchange && !any_err
        |=> run_led == $past(flash_r) && !error_led && !maintenance_indicator)
        else $error("startup indicator pattern wrong");

    exchange_run_a: assert property (in_run && data_exchange |=> run_led)
        else $error("run indicator not steady in data exchange");

    error_flash_a: assert property (in_run && valid_r && (group_error || pend_r)
        |=> error_led == $past(flash_r))
        else $error("error indicator not flashing on error");

    param_quiet_a: assert property (in_run && valid_r && io_param_error && !any_err
        |=> !error_led)
        else $error("io parameter error shown on indicator");

    diag_entry_a: assert property (s_alarm |=>
        pend_r && chan_r[$past(diag_channel)])
        else $error("alarm not entered into diagnostics");

    irq_hold_a: assert property (s_pending_unacked |=> pend_r
        && queued_r == ($past(queued_r) || $past(alarm_ok)))
        else $error("pending interrupt dropped without ack");

    ack_clear_a: assert property (s_ack_idle |=> !pend_r)
        else $error("pending interrupt not cleared by ack");

    frame_len_a: assert property (frame_len >= 8'(SAI_FRAME_HDR)
        && frame_len <= 8'(SAI_FRAME_MAX))
        else $error("frame length out of range");
endmodule

// ---- testbench/sai_master_model.sv ----
// bus master stand-in that acknowledges diagnostic interrupts
`timescale 1ns/1ps
module sai_master_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // interrupt handshake
    input  wire logic       diag_int_pending,
    input  wire logic [7:0] ack_delay,
    output logic            diag_ack
);
    logic [7:0] wait_r;

    // one ack per raised interrupt, after a settable delay
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wait_r   <= 8'h00;
            diag_ack <= 1'b0;
        end
        else
        begin
            diag_ack <= 1'b0;
            if (diag_int_pending && !diag_ack && wait_r < ack_delay)
                wait_r <= wait_r + 8'h01;
            else if (diag_int_pending && !diag_ack)
            begin
                // skip the edge after an ack: pending may stay up for a queued alarm
                diag_ack <= 1'b1;
                wait_r   <= 8'h00;
            end
        end
    end
endmodule

// ---- testbench/tb_top.sv ----
// self-checking bench for the station address and status indicator block
`timescale 1ns/1ps
module tb_top;
    import sai_pkg::*;
    localparam int FLASH = 4;
    logic        clk          = 1'b0;
    logic        reset_n      = 1'b0;
    logic [6:0]  addr_switch  = 7'h00;
    logic [8:0]  mode         = 9'h000;
    logic        diag_alarm   = 1'b0;
    logic [2:0]  diag_channel = 3'h0;
    logic [7:0]  reg_addr     = 8'h00;
    logic [31:0] reg_wdata    = 32'h0;
    logic        reg_wr       = 1'b0;
    logic        reg_rd       = 1'b0;
    logic [7:0]  ack_delay    = 8'h3C;
    logic        diag_ack;
    logic [31:0] reg_rdata;
    logic        run_led;
    logic        error_led;
    logic        maintenance_indicator;
    logic [6:0]  station_addr;
    logic        addr_valid;
    logic        bus_enable;
    logic        diag_int_pending;
    logic [7:0]  frame_len;
    logic        irq;
    logic [2:0]  leds;
    int          err_total = 0;
    int          checked   = 0;
    int          seed      = 32'h351b4a9a;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic        rd_d      = 1'b0;
    logic [6:0]  good;
    logic [6:0]  adr_tab[5] = '{7'h00, 7'h7E, 7'h7F, 7'h01, 7'h7D};
    logic [7:0]  irq_a[5] = '{SAI_IRQ_MASK_OFS, SAI_IRQ_MASK_OFS, SAI_IRQ_STAT_OFS,
                              SAI_IRQ_MASK_OFS, SAI_IRQ_STAT_OFS};
    logic [31:0] irq_d[5] = '{32'h0, 32'h4, 32'h4, 32'h1, 32'h1};
    logic        irq_e[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    int          ch;
    int          n;
    logic        v;

    assign leds = {maintenance_indicator, error_led, run_led};

    always #12.5 clk = ~clk;

    // short counts keep the lamp and flash phases within a few dozen cycles
    sai_top #(.NCH(8), .LAMP_CYC(16), .FLASH_CYC(FLASH)) i_sai_top (
        .clk(clk), .reset_n(reset_n), .addr_switch(addr_switch),
        .mod_deactivated(mode[0]), .mod_not_configured(mode[1]),
        .mod_starting(mode[2]), .mod_configuring(mode[3]), .data_exchange(mode[4]),
        .group_error(mode[5]), .config_mismatch(mode[6]), .invalid_config(mode[7]),
        .io_param_error(mode[8]), .diag_alarm(diag_alarm), .diag_channel(diag_channel),
        .diag_ack(diag_ack), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .run_led(run_led),
        .error_led(error_led), .maintenance_indicator(maintenance_indicator),
        .station_addr(station_addr), .addr_valid(addr_valid), .bus_enable(bus_enable),
        .diag_int_pending(diag_int_pending), .frame_len(frame_len), .irq(irq));

    sai_master_model i_sai_master_model (
        .clk(clk), .reset_n(reset_n), .diag_int_pending(diag_int_pending),
        .ack_delay(ack_delay), .diag_ack(diag_ack));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge clk)
    begin
        if (rd_d)
            chk(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
        rd_d = reg_rd;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk);
        exp_q.push_back(e);
        msk_q.push_back(m);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
    endtask

    // result: 0 or 1 for a steady level, 2 for flashing
    task automatic led(input int sel, input logic [31:0] exp);
        logic [2:0]  prev;
        int          t;
        logic [31:0] r;
        t = 0;
        @(negedge clk);
        prev = leds;
        repeat (3 * FLASH)
        begin
            @(negedge clk);
            if (leds[sel] !== prev[sel])
                t++;
            prev = leds;
        end
        r = (t >= 2) ? 32'h2 : {31'h0, leds[sel]};
        chk(r, exp);
    endtask

    task automatic do_reset(input logic [6:0] a, input int cyc);
        @(posedge clk);
        reset_n     <= 1'b0;
        addr_switch <= a;
        repeat (cyc) @(posedge clk);
        reset_n     <= 1'b1;
    endtask

    task automatic alarm(input int c);
        @(posedge clk);
        diag_alarm   <= 1'b1;
        diag_channel <= 3'(c);
        @(posedge clk);
        diag_alarm   <= 1'b0;
    endtask

    task automatic wait_ack();
        n = 0;
        while (diag_ack !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        @(negedge clk);
    endtask

    initial
    begin
        good = 7'd1 + 7'($unsigned($random(seed)) % 125);
        do_reset(good, 20);
        repeat (18) @(posedge clk);
        addr_switch <= good ^ 7'h7F;
        @(negedge clk);
        chk(leds, 32'h7);
        repeat (6) @(negedge clk);
        chk(maintenance_indicator, 1'b0);
        chk(station_addr, good);
        rd(SAI_STATUS_OFS, 32'h300 | good, 32'hFFF);
        rd(SAI_CTRL_OFS, 32'h0, 32'h1);
        rd(SAI_IRQ_MASK_OFS, 32'h0, 32'h7);
        rd(8'h20, 32'h0, 32'hFFFFFFFF);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            mode <= 9'(1 << i);
            led(0, 2);
            led(1, 0);
            led(2, 0);
        end
        for (int i = 5; i < 8; i++)
        begin
            @(posedge clk);
            mode <= 9'h010 | 9'(1 << i);
            led(0, 1);
            led(1, 2);
        end
        @(posedge clk);
        mode <= 9'h110;
        led(1, 0);
        alarm(3);
        @(negedge clk);
        chk(diag_int_pending, 1'b0);
        wr(SAI_CTRL_OFS, 32'h1);
        ch = $unsigned($random(seed)) % 8;
        alarm(ch);
        @(negedge clk);
        chk(diag_int_pending, 1'b1);
        @(negedge clk);
        chk(frame_len, 8'(SAI_FRAME_HDR + SAI_INT_BLK_BYTES + SAI_ENTRY_BYTES));
        rd(SAI_CHAN_DIAG_OFS, 32'(1 << ch), 32'hFF);
        rd(SAI_IRQ_STAT_OFS, 32'h1, 32'h1);
        led(1, 2);
        alarm((ch + 1) % 8);
        wait_ack();
        chk(diag_int_pending, 1'b1);
        n = SAI_FRAME_HDR + SAI_INT_BLK_BYTES + 2 * SAI_ENTRY_BYTES;
        chk(frame_len, 32'(n));
        wait_ack();
        chk(diag_int_pending, 1'b0);
        rd(SAI_IRQ_STAT_OFS, 32'h5, 32'h7);
        wr(SAI_CHAN_DIAG_OFS, 32'hFF);
        repeat (3) @(negedge clk);
        chk(frame_len, 8'(SAI_FRAME_HDR));
        for (int i = 0; i < 5; i++)
        begin
            wr(irq_a[i], irq_d[i]);
            @(negedge clk);
            chk(irq, irq_e[i]);
        end
        // power cycles across both range edges and the three reserved addresses
        for (int i = 0; i < 5; i++)
        begin
            v = (i >= 3);
            do_reset(adr_tab[i], 2);
            repeat (30) @(posedge clk);
            addr_switch <= good;
            rd(SAI_STATUS_OFS, {23'h0, v, 1'b0, adr_tab[i]}, 32'h17F);
            rd(SAI_IRQ_STAT_OFS, {30'h0, !v, 1'b0}, 32'h2);
            chk(bus_enable, v);
            if (!v)
            begin
                led(0, 1);
                led(1, 1);
                led(2, 0);
            end
        end
        repeat (4) @(posedge clk);
        final_report();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        final_report();
    end
endmodule
